// File: hw/timer_counter.sv
// 8/16-bit timer/counter with 8-bit prescaler, overflow flag and Avalon-MM register slave
// assumes one 100 MHz clock; ext_count_pin is asynchronous and is synchronised here
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none

module timer_counter (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire timer_pkg::bus_req_type bus_req,
  output var  logic [31:0]          readdata,
  output var  logic                 waitrequest,
  input  wire logic                 ext_count_pin,
  input  wire logic                 sleep_active,
  output var  logic                 overflow_irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    timer_pkg::bus_state_type bus_state;
    logic                     wait_n;
    logic [31:0]              rdata;
    logic [7:0]               control;
    logic [7:0]               count_low;
    logic [7:0]               count_high;
    logic [7:0]               high_buffer;
    logic [7:0]               prescale;
    logic [1:0]               instr_div;
    logic [1:0]               inhibit;
    logic                     irq_enable;
    logic                     flag;
    logic                     irq;
  } timer_state_type;

  timer_state_type st_r;
  timer_state_type st_nxt;

  logic pin_edge;

  // ****************************************
  // pin synchroniser
  // ****************************************
  pin_edge_sync u_pin_edge_sync (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .pin_in      (ext_count_pin),
    .falling_sel (st_r.control[timer_pkg::EDGE_SELECT_BIT]),
    .edge_pulse  (pin_edge)
  );

  // ****************************************
  // control decode
  // ****************************************
  logic       run_enable;
  logic       width_select;
  logic       source_select;
  logic       prescaler_bypass;
  logic [2:0] prescale_ratio;
  logic       instr_tick;
  logic       src_tick;
  logic [7:0] ratio_mask;
  logic       pre_tick;
  logic       inc;

  assign run_enable       = st_r.control[timer_pkg::RUN_ENABLE_BIT];
  assign width_select     = st_r.control[timer_pkg::WIDTH_SELECT_BIT];
  assign source_select    = st_r.control[timer_pkg::SOURCE_SELECT_BIT];
  assign prescaler_bypass = st_r.control[timer_pkg::PRESCALER_BYPASS_BIT];
  assign prescale_ratio   = st_r.control[timer_pkg::RATIO_LSB +: timer_pkg::RATIO_W];

  // one instruction cycle spans several ref_clk cycles
  assign instr_tick = (st_r.instr_div == timer_pkg::INSTR_DIV_LAST);

  // pin pulse is already three flops late, which is the documented post-sync delay
  assign src_tick = source_select ? pin_edge : instr_tick;

  // mask of ratio+1 low ones: the prescaler emits a tick as those bits roll over
  assign ratio_mask = 8'((9'h002 << prescale_ratio) - 9'h001);

  assign pre_tick = src_tick & ((st_r.prescale & ratio_mask) == ratio_mask);

  // sleep stops counting, so no overflow can arise to wake the core
  assign inc = run_enable & ~sleep_active & (st_r.inhibit == 2'h0)
             & (prescaler_bypass ? src_tick : pre_tick);

  // ****************************************
  // bus decode
  // ****************************************
  logic       accept;
  logic       wr_lane;
  logic [7:0] wbyte;
  logic       wr_ctrl;
  logic       wr_low;
  logic       wr_hbuf;
  logic       wr_int;
  logic       rd_low_capture;

  // the access takes effect at the edge where waitrequest is seen low
  assign accept  = (st_r.bus_state == timer_pkg::BUS_ACK);
  assign wr_lane = accept & bus_req.write & bus_req.byteenable[0];
  assign wbyte   = bus_req.writedata[7:0];
  assign wr_ctrl = wr_lane & (bus_req.address == timer_pkg::TIMER_CONTROL_OFS);
  assign wr_low  = wr_lane & (bus_req.address == timer_pkg::COUNT_LOW_BYTE_OFS);
  assign wr_hbuf = wr_lane & (bus_req.address == timer_pkg::COUNT_HIGH_BUFFER_OFS);
  assign wr_int  = wr_lane & (bus_req.address == timer_pkg::INTERRUPT_CONTROL_OFS);

  // high byte is copied in the same edge that samples the low byte
  assign rd_low_capture = (st_r.bus_state == timer_pkg::BUS_IDLE) & bus_req.read
                        & ~bus_req.write
                        & (bus_req.address == timer_pkg::COUNT_LOW_BYTE_OFS);

  // ****************************************
  // next state
  // ****************************************
  logic [15:0] count16;
  logic [15:0] count16_inc;
  logic        wrap;
  logic [7:0]  rbyte;

  always_comb
  begin
    st_nxt      = st_r;
    count16     = {st_r.count_high, st_r.count_low};
    count16_inc = count16 + 16'h0001;
    wrap        = 1'b0;
    rbyte       = 8'h00;

    // instruction cycle divider runs freely
    st_nxt.instr_div = instr_tick ? 2'h0 : 2'(st_r.instr_div + 2'h1);

    // inhibit window counts down in instruction cycles
    if (instr_tick && st_r.inhibit != 2'h0)
    begin
      st_nxt.inhibit = 2'(st_r.inhibit - 2'h1);
    end

    // prescaler advances on every source tick, even while the timer is stopped, except where a count write with the prescaler in use clears it
    if (src_tick)
    begin
      st_nxt.prescale = 8'(st_r.prescale + 8'h01);
    end

    // counting
    if (inc)
    begin
      if (width_select)
      begin
        st_nxt.count_low = 8'(st_r.count_low + 8'h01);
        wrap             = (st_r.count_low == 8'hff);
      end
      else
      begin
        st_nxt.count_low  = count16_inc[7:0];
        st_nxt.count_high = count16_inc[15:8];
        wrap              = (count16 == 16'hffff);
      end
    end

    // bus slave: one wait cycle, then accept
    case (st_r.bus_state)
      timer_pkg::BUS_IDLE:
      begin
        st_nxt.wait_n = 1'b0;
        if (bus_req.read ^ bus_req.write)
        begin
          case (bus_req.address)
            timer_pkg::TIMER_CONTROL_OFS:     rbyte = st_r.control;
            timer_pkg::COUNT_LOW_BYTE_OFS:    rbyte = st_r.count_low;
            timer_pkg::COUNT_HIGH_BUFFER_OFS: rbyte = st_r.high_buffer;
            timer_pkg::INTERRUPT_CONTROL_OFS:
            begin
              rbyte                               = 8'h00;
              rbyte[timer_pkg::IRQ_ENABLE_BIT]    = st_r.irq_enable;
              rbyte[timer_pkg::OVERFLOW_FLAG_BIT] = st_r.flag;
            end
            default: rbyte = 8'h00;
          endcase
          st_nxt.rdata     = {24'h00_0000, rbyte};
          st_nxt.wait_n    = 1'b1;
          st_nxt.bus_state = timer_pkg::BUS_ACK;
        end
      end
      timer_pkg::BUS_ACK:
      begin
        st_nxt.wait_n    = 1'b0;
        st_nxt.bus_state = timer_pkg::BUS_IDLE;
      end
      default:
      begin
        st_nxt.wait_n    = 1'b0;
        st_nxt.bus_state = timer_pkg::BUS_IDLE;
      end
    endcase

    if (rd_low_capture)
    begin
      st_nxt.high_buffer = st_r.count_high;
    end

    // prescaler setting may change any time; only the control byte is steered here
    if (wr_ctrl)
    begin
      st_nxt.control = wbyte;
    end

    if (wr_hbuf)
    begin
      st_nxt.high_buffer = wbyte;
    end

    // a count write wins over an increment in the same cycle
    if (wr_low)
    begin
      st_nxt.count_low = wbyte;
      if (!width_select)
      begin
        st_nxt.count_high = st_r.high_buffer;
      end
      st_nxt.inhibit = timer_pkg::WRITE_INHIBIT;
      if (!prescaler_bypass)
      begin
        st_nxt.prescale = 8'h00;
      end
    end

    if (wr_int)
    begin
      st_nxt.irq_enable = wbyte[timer_pkg::IRQ_ENABLE_BIT];
      st_nxt.flag       = wbyte[timer_pkg::OVERFLOW_FLAG_BIT];
    end

    // a wrap in the clearing cycle keeps the flag set
    if (wrap)
    begin
      st_nxt.flag = 1'b1;
    end

    st_nxt.irq = st_nxt.flag & st_nxt.irq_enable;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r             <= '0;
      st_r.bus_state   <= timer_pkg::BUS_IDLE;
      st_r.control     <= timer_pkg::TIMER_CONTROL_RST;
      st_r.count_low   <= timer_pkg::COUNT_LOW_BYTE_RST;
      st_r.count_high  <= timer_pkg::COUNT_HIGH_RST;
      st_r.high_buffer <= timer_pkg::COUNT_HIGH_BUFFER_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // waitrequest is high except in the single accept cycle
  assign waitrequest  = ~st_r.wait_n;
  assign readdata     = st_r.rdata;
  assign overflow_irq = st_r.irq;

endmodule // timer_counter

`default_nettype wire

// File: inc/timer_pkg.sv
// timer/counter package: register map, field positions, reset values, timing counts
// assumes a 100 MHz ref_clk and an Avalon-MM slave with 32-bit data and byte addressing
`default_nettype none

package timer_pkg;

  // ****************************************
  // bus carrier
  // ****************************************
  localparam int ADDR_W = 4;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
  } bus_req_type;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] TIMER_CONTROL_OFS     = 4'h0;
  localparam logic [ADDR_W-1:0] COUNT_LOW_BYTE_OFS    = 4'h4;
  localparam logic [ADDR_W-1:0] COUNT_HIGH_BUFFER_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] INTERRUPT_CONTROL_OFS = 4'hc;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RUN_ENABLE_BIT       = 7;
  localparam int WIDTH_SELECT_BIT     = 6;
  localparam int SOURCE_SELECT_BIT    = 5;
  localparam int EDGE_SELECT_BIT      = 4;
  localparam int PRESCALER_BYPASS_BIT = 3;
  localparam int RATIO_LSB            = 0;
  localparam int RATIO_W              = 3;
  localparam int IRQ_ENABLE_BIT       = 5;
  localparam int OVERFLOW_FLAG_BIT    = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] TIMER_CONTROL_RST     = 8'hff;
  localparam logic [7:0] COUNT_LOW_BYTE_RST    = 8'h00;
  localparam logic [7:0] COUNT_HIGH_RST        = 8'h00;
  localparam logic [7:0] COUNT_HIGH_BUFFER_RST = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int          INSTR_CLK_DIV  = 4;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'(INSTR_CLK_DIV - 1);
  localparam logic [1:0]  WRITE_INHIBIT  = 2'h2;

  // ****************************************
  // bus slave states
  // ****************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_type;

endpackage

`default_nettype wire

// File: hw/pin_edge_sync.sv
// two-stage synchroniser and edge detector for the external count pin
// assumes the pin is asynchronous to ref_clk; output is a one-cycle pulse
`default_nettype none

module pin_edge_sync (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  input  wire logic falling_sel,
  output var  logic edge_pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // meta feeds only sync; the edge is seen between sync and last
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.meta  = pin_in;
    st_nxt.sync  = st_r.meta;
    st_nxt.last  = st_r.sync;
    st_nxt.pulse = falling_sel ? (st_r.last & ~st_r.sync) : (~st_r.last & st_r.sync);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign edge_pulse = st_r.pulse;

endmodule // pin_edge_sync

`default_nettype wire

// File: verification/timer_counter_properties.sv
// checker for timer_counter: bus handshake, readback and interrupt output
// assumes it is bound into timer_counter and sees only its ports
`default_nettype none

module timer_counter_properties (
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  input wire timer_pkg::bus_req_type bus_req,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  input wire logic                   overflow_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // shadow of what software wrote
  // ****
  typedef struct packed {logic en; logic [7:0] ctl;} shadow_type;
  shadow_type shadow_r;
  shadow_type shadow_nxt;
  logic       acc;
  logic       wr_any;
  logic       wr_c;
  assign acc    = (bus_req.read ^ bus_req.write) && !waitrequest;
  assign wr_any = acc && bus_req.write && bus_req.byteenable[0];
  assign wr_c   = wr_any && bus_req.address == timer_pkg::INTERRUPT_CONTROL_OFS;
  always_comb
  begin
    shadow_nxt = shadow_r;
    if (wr_any && bus_req.address == timer_pkg::TIMER_CONTROL_OFS)
      shadow_nxt.ctl = bus_req.writedata[7:0];
    if (wr_c)
      shadow_nxt.en = bus_req.writedata[timer_pkg::IRQ_ENABLE_BIT];
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      shadow_r <= {1'b0, timer_pkg::TIMER_CONTROL_RST};
    else
      shadow_r <= shadow_nxt;
  end
  // ****
  // properties
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_request; (bus_req.read ^ bus_req.write) && waitrequest; endsequence
  sequence s_answer; !waitrequest ##1 waitrequest; endsequence
  a_request_answered: assert property (s_request |-> ##[1:2] !waitrequest)
    else $error("request not answered");
  a_wait_single: assert property ($fell(waitrequest) |-> s_answer)
    else $error("waitrequest low too long");
  a_answer_cause: assert property ($fell(waitrequest) |-> $past(bus_req.read ^ bus_req.write))
    else $error("answer without request");
  a_both_refused: assert property (bus_req.read && bus_req.write |=> waitrequest)
    else $error("read and write together accepted");
  a_unmapped_zero: assert property (acc && bus_req.read && bus_req.address[1:0] != 2'h0
    |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_control_kept: assert property (acc && bus_req.read
    && bus_req.address == timer_pkg::TIMER_CONTROL_OFS |-> readdata == {24'h00_0000, shadow_r.ctl})
    else $error("control readback differs");
  a_irq_masked: assert property (!shadow_r.en && !$past(shadow_r.en) |-> !overflow_irq)
    else $error("irq while masked");
  // enable and irq update at the same edge, so the current shadow is the one to check
  a_irq_enabled: assert property ($rose(overflow_irq) |-> shadow_r.en)
    else $error("irq rose without enable");
  a_flag_sticky: assert property ($fell(overflow_irq) |-> $past(wr_c) || $past(wr_c, 2))
    else $error("irq dropped without software write");
  a_intctl_bits: assert property (acc && bus_req.read
    && bus_req.address == timer_pkg::INTERRUPT_CONTROL_OFS
    |-> (readdata & 32'h0000_00db) == 32'h0000_0000 && readdata[5] == shadow_r.en)
    else $error("interrupt control readback wrong");
endmodule // timer_counter_properties

bind timer_counter timer_counter_properties u_timer_counter_properties (
  .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .readdata(readdata),
  .waitrequest(waitrequest), .overflow_irq(overflow_irq));

`default_nettype wire

// File: verification/ext_clock_source.sv
// external clock source on the count pin: a burst of level toggles on request
// assumes start is a one-cycle pulse; the pin holds its last level between bursts
`default_nettype none

module ext_clock_source (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [4:0] toggles,
  input  wire logic [2:0] half,
  output var  logic       pin,
  output var  logic       busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] left_r;
  logic [2:0] cnt_r;
  // each level lasts half cycles, at least two, so the synchroniser can see it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin    <= 1'b0;
      busy   <= 1'b0;
      left_r <= 5'h00;
      cnt_r  <= 3'h0;
    end
    else if (start && !busy)
    begin
      busy   <= 1'b1;
      left_r <= toggles;
      cnt_r  <= half;
    end
    else if (busy && cnt_r == 3'h1)
    begin
      pin    <= ~pin;
      left_r <= left_r - 5'h01;
      cnt_r  <= half;
      busy   <= left_r != 5'h01;
    end
    else if (busy)
      cnt_r <= cnt_r - 3'h1;
  end
endmodule // ext_clock_source

`default_nettype wire

// File: verification/timer0_counter_prescaler_test.sv
// self-checking bench for timer_counter with a pin clock source model
// assumes the checker is bound in and a 100 MHz ref_clk
`default_nettype none

module timer0_counter_prescaler_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, waitrequest, ext_count_pin, sleep_active, overflow_irq;
  logic src_start, src_busy, lvl;
  timer_pkg::bus_req_type bus_req;
  logic [31:0] readdata;
  logic [4:0]  src_toggles, tg;
  logic [2:0]  src_half;
  logic [15:0] lfsr_r;
  logic [7:0]  q, q2, d1, d2;
  logic [3:0]  ofs [5];
  int          error_cnt, tests_run, n;

  timer_counter u_timer_counter (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
    .readdata(readdata), .waitrequest(waitrequest), .ext_count_pin(ext_count_pin),
    .sleep_active(sleep_active), .overflow_irq(overflow_irq));
  ext_clock_source u_ext_clock_source (.ref_clk(ref_clk), .rstn(rstn), .start(src_start),
    .toggles(src_toggles), .half(src_half), .pin(ext_count_pin), .busy(src_busy));
  // ****
  // helpers
  // ****
  task automatic rnd(output logic [7:0] v);
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    v = lfsr_r[7:0];
  endtask
  function automatic logic [7:0] edges_exp(input logic lv, input logic [4:0] t, input logic fl);
    logic [4:0] rise;
    rise = lv ? t >> 1 : (t + 5'h01) >> 1;
    return 8'(fl ? t - rise : rise);
  endfunction
  function automatic int span(input int r);
    return (r == 8) ? 4 : 4 << (r + 1);
  endfunction
  task automatic bus(input logic w, input int i, input logic [7:0] d, output logic [7:0] rq);
    int k;
    @(posedge ref_clk);
    bus_req.read <= !w;
    bus_req.write <= w;
    bus_req.address <= ofs[i];
    bus_req.writedata <= {24'h00_0000, d};
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 40);
    rq = readdata[7:0];
    if (k >= 40)
    begin
      error_cnt++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s ended, mismatches so far %0d", s, error_cnt);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****
  // clock, watchdog, tests
  // ****
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    // about six and a half times the longest expected run
    #300000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  initial
  begin
    bus_req = '0;
    bus_req.byteenable = 4'h1;
    ofs = '{timer_pkg::TIMER_CONTROL_OFS, timer_pkg::COUNT_LOW_BYTE_OFS,
            timer_pkg::COUNT_HIGH_BUFFER_OFS, timer_pkg::INTERRUPT_CONTROL_OFS, 4'h2};
    {rstn, sleep_active, src_start, lvl, src_toggles, src_half} = '0;
    lfsr_r = 16'h2506;
    error_cnt = 0;
    tests_run = 0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      bus(0, i, 8'h00, q);
      chk(q, (i == 0) ? timer_pkg::TIMER_CONTROL_RST : 8'h00);
    end
    done("reset");
    rnd(d1);
    rnd(d2);
    bus(1, 0, 8'h08, q);
    bus(1, 2, d1, q);
    bus(1, 1, d2, q);
    bus(0, 1, 8'h00, q); chk(q, d2);
    bus(0, 2, 8'h00, q); chk(q, d1);
    bus(1, 2, ~d1, q);
    bus(0, 1, 8'h00, q);
    bus(0, 2, 8'h00, q); chk(q, d1);
    done("buffer");
    for (int r = 0; r <= 8; r++)
    begin
      bus(1, 0, (r == 8) ? 8'h88 : 8'h80 | 8'(r), q);
      bus(0, 1, 8'h00, q);
      repeat (2 * span(r) - 3) @(posedge ref_clk);
      bus(0, 1, 8'h00, q2); chk(q2 - q, 8'h02);
    end
    sleep_active <= 1'b1;
    bus(0, 1, 8'h00, q);
    repeat (37) @(posedge ref_clk);
    bus(0, 1, 8'h00, q2); chk(q2 - q, 8'h00);
    sleep_active <= 1'b0;
    done("rates");
    bus(1, 3, 8'h20, q);
    bus(1, 2, 8'hff, q);
    bus(1, 1, 8'hfd, q);
    repeat (40) @(posedge ref_clk);
    chk({7'h00, overflow_irq}, 8'h01);
    bus(0, 3, 8'h00, q); chk(q, 8'h24);
    bus(0, 1, 8'h00, q);
    bus(0, 2, 8'h00, q); chk(q, 8'h00);
    bus(1, 3, 8'h00, q);
    repeat (3) @(posedge ref_clk);
    chk({7'h00, overflow_irq}, 8'h00);
    bus(0, 3, 8'h00, q); chk(q, 8'h00);
    bus(1, 3, 8'h20, q);
    bus(0, 3, 8'h00, q); chk(q, 8'h20);
    bus(1, 0, 8'hc8, q);
    bus(1, 2, 8'h5a, q);
    bus(1, 1, 8'hfd, q);
    repeat (40) @(posedge ref_clk);
    bus(0, 3, 8'h00, q); chk(q, 8'h24);
    bus(0, 1, 8'h00, q);
    bus(0, 2, 8'h00, q); chk(q, 8'h00);
    bus(1, 3, 8'h00, q);
    done("overflow");
    for (int e = 0; e < 2; e++)
    begin
      bus(1, 0, 8'ha8 | 8'(e << 4), q);
      bus(1, 1, 8'h00, q);
      repeat (10) @(posedge ref_clk);
      rnd(d1);
      tg = 5'(d1[3:0]) + 5'h01;
      src_toggles <= tg;
      src_half <= 3'h2 + 3'(d1[5:4]);
      src_start <= 1'b1;
      @(posedge ref_clk);
      src_start <= 1'b0;
      @(posedge ref_clk);
      for (n = 0; src_busy === 1'b1 && n < 500; n++)
        @(posedge ref_clk);
      repeat (10) @(posedge ref_clk);
      bus(0, 1, 8'h00, q); chk(q, edges_exp(lvl, tg, e[0]));
      lvl = lvl ^ tg[0];
    end
    done("pin");
    bus_req.read <= 1'b1;
    bus_req.write <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    repeat (4) @(posedge ref_clk);
    done("refused");
    give_verdict();
  end
endmodule // timer0_counter_prescaler_test

`default_nettype wire
